// ---- verilog/dual_timer_defines.svh ----
// register map, field positions, reset values and tick counts of the dual timer
// Behaviour
// (RL1) overflow sets flag; vectoring clears it
// (RL2) run bit stops or starts each timer
// (RL3) external flag set on detect, edge-cleared
// (RL4) type bit: low level or falling edge
// (RL5) gating needs pin high plus run bit
// (RL6) source: divided clock or event falling edges
// (RL7) mode 00: 8-bit counter, 5-bit prescaler
// (RL8) mode 01: cascaded 16-bit counter
// (RL9) mode 10: low byte reloads from high
// (RL10) timer 1 mode 11 holds its count
// (RL11) timer 0 mode 11 splits, borrows timer1 bits
// (RL12) mode register resets to all zeros
// (RL13) count bytes readable and writable separately
// (RL14) overflow is all-ones to zero rollover
// (RL15) prescale uses low five bits only
// (RL16) reload leaves high byte, writable anytime
// (RL17) halving bit or X2 selects timer clock
// (RL18) timer ticks every six timer-clock periods
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

`define OFS_CTL_FLAGS   8'h88
`define OFS_MODE_SEL    8'h89
`define OFS_LO0         8'h8a
`define OFS_LO1         8'h8b
`define OFS_HI0         8'h8c
`define OFS_HI1         8'h8d
`define OFS_CLK_CFG     8'h8e
`define OFS_INT_STATUS  8'h90
`define OFS_INT_CLEAR   8'h91
`define OFS_INT_ENABLE  8'h92

`define CTL_OVF1        7
`define CTL_RUN1        6
`define CTL_OVF0        5
`define CTL_RUN0        4
`define CTL_EXT1_FLAG   3
`define CTL_EXT1_EDGE   2
`define CTL_EXT0_FLAG   1
`define CTL_EXT0_EDGE   0

`define MODE_TIMER1_PIN_GATING      7
`define MODE_SRC1       6
`define MODE1_HI        5
`define MODE1_LO        4
`define MODE_TIMER0_PIN_GATING      3
`define MODE_SRC0       2
`define MODE0_HI        1
`define MODE0_LO        0

`define RST_CTL_FLAGS   8'h00
`define RST_MODE_SEL    8'h00
`define RST_COUNT       8'h00

`define TIMER_TICK_DIV  6
`define OSC_HALF_DIV    2
`define TICK_LIM_FAST   (`TIMER_TICK_DIV - 1)
`define TICK_LIM_SLOW   (`TIMER_TICK_DIV * `OSC_HALF_DIV - 1)

`endif

// ---- verilog/timer_pkg.sv ----
// types shared by the dual timer
package timer_pkg;

   typedef enum logic [1:0] {
      MODE_PRESCALE = 2'b00,
      MODE_CASCADE  = 2'b01,
      MODE_RELOAD   = 2'b10,
      MODE_SPLIT    = 2'b11
   } mode_e;

   typedef struct packed {
      logic [7:0] ctl_flags;
      logic [7:0] mode_sel;
      logic [7:0] lo0;
      logic [7:0] hi0;
      logic [7:0] lo1;
      logic [7:0] hi1;
      logic [1:0] clk_cfg;
      logic [3:0] sts;
      logic [3:0] ien;
      logic [3:0] pre0;
      logic [3:0] pre1;
      logic [3:0] sync_a;
      logic [3:0] sync_b;
      logic [3:0] sync_prev;
      logic [7:0] rdata;
   } state_s;

endpackage

// ---- verilog/dual_timer_counter.sv ----
// two timer/counters with control, mode and interrupt registers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "dual_timer_defines.svh"

module dual_timer_counter (
   // clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       SYS_RST,
   // register port
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   // external pins
   input  wire logic       EXT_IRQ0_PIN,
   input  wire logic       EXT_IRQ1_PIN,
   input  wire logic       TIMER0_EVENT_PIN,
   input  wire logic       TIMER1_EVENT_PIN,
   // processor side
   input  wire logic       X2_MODE,
   input  wire logic       VEC_TIMER0,
   input  wire logic       VEC_TIMER1,
   input  wire logic       VEC_EXT0,
   input  wire logic       VEC_EXT1,
   // interrupt
   output logic            IRQ
);

   timer_pkg::state_s q;
   timer_pkg::state_s d;

   logic [3:0]  lim0;
   logic [3:0]  lim1;
   logic        tick0;
   logic        tick1;
   logic [3:0]  fall;
   logic        split0;
   logic        run0;
   logic        run1;
   logic        inc0;
   logic        inc1;
   logic        hi_inc;
   logic [16:0] step0;
   logic [16:0] step1;
   logic        ovf0;
   logic        ovf_hi;
   logic        ovf1;
   logic        set_ovf0;
   logic        set_ovf1;
   logic        set_ext0;
   logic        set_ext1;
   logic        wr_ctl;
   logic        wr_cnt0;
   logic        wr_cnt1;
   logic [7:0]  ctl_base;

   // one count step for modes 0..2; mode 3 holds
   function automatic logic [16:0] step(input timer_pkg::mode_e m,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      unique case (m)
         timer_pkg::MODE_PRESCALE: begin
            // upper three low-byte bits are left alone [RL15]
            r[4:0] = lo[4:0] + 5'h01; // [RL7]
            if (lo[4:0] == 5'h1f) begin
               r[16:8] = {hi == 8'hff, hi + 8'h01}; // [RL14]
            end
         end
         timer_pkg::MODE_CASCADE: begin
            r = {({hi, lo} == 16'hffff), {hi, lo} + 16'h0001}; // [RL8] [RL14]
         end
         timer_pkg::MODE_RELOAD: begin
            if (lo == 8'hff) begin
               r = {1'b1, hi, hi}; // [RL9] [RL16]
            end else begin
               r[7:0] = lo + 8'h01;
            end
         end
         timer_pkg::MODE_SPLIT: begin
            r = {1'b0, hi, lo}; // [RL10]
         end
      endcase
      return r;
   endfunction

   // halving bit or standard mode doubles the tick period [RL17]
   assign lim0 = (q.clk_cfg[0] | ~X2_MODE) ? 4'(`TICK_LIM_SLOW) : 4'(`TICK_LIM_FAST);
   assign lim1 = (q.clk_cfg[1] | ~X2_MODE) ? 4'(`TICK_LIM_SLOW) : 4'(`TICK_LIM_FAST);
   assign tick0 = (q.pre0 >= lim0); // [RL18]
   assign tick1 = (q.pre1 >= lim1); // [RL18]

   // falling edges of the synchronised pins
   assign fall = q.sync_prev & ~q.sync_b;

   assign split0 = (q.mode_sel[`MODE0_HI:`MODE0_LO] == 2'b11);

   assign run0 = q.ctl_flags[`CTL_RUN0] & (~q.mode_sel[`MODE_TIMER0_PIN_GATING] | q.sync_b[0]); // [RL2] [RL5]
   // in split mode timer 1 loses its run bit and is stopped only by mode 3 or its gate pin
   assign run1 = (split0 | q.ctl_flags[`CTL_RUN1])
               & (~q.mode_sel[`MODE_TIMER1_PIN_GATING] | q.sync_b[1]); // [RL2] [RL5]
   assign inc0 = run0 & (q.mode_sel[`MODE_SRC0] ? fall[2] : tick0); // [RL6]
   assign inc1 = run1 & (q.mode_sel[`MODE_SRC1] ? fall[3] : tick1); // [RL6]
   assign hi_inc = split0 & q.ctl_flags[`CTL_RUN1] & tick0; // [RL11]

   assign step0 = step(timer_pkg::mode_e'(q.mode_sel[`MODE0_HI:`MODE0_LO]), q.lo0, q.hi0);
   assign step1 = step(timer_pkg::mode_e'(q.mode_sel[`MODE1_HI:`MODE1_LO]), q.lo1, q.hi1);

   assign ovf0 = inc0 & (split0 ? (q.lo0 == 8'hff) : step0[16]); // [RL14]
   assign ovf_hi = hi_inc & (q.hi0 == 8'hff); // [RL11]
   assign ovf1 = inc1 & step1[16];
   assign set_ovf0 = ovf0;
   assign set_ovf1 = ovf_hi | (ovf1 & ~split0); // [RL11]

   // level mode flags while low, edge mode on a falling edge [RL4]
   assign set_ext0 = q.ctl_flags[`CTL_EXT0_EDGE] ? fall[0] : ~q.sync_b[0];
   assign set_ext1 = q.ctl_flags[`CTL_EXT1_EDGE] ? fall[1] : ~q.sync_b[1];

   assign wr_ctl = REG_WR & (REG_ADDR == `OFS_CTL_FLAGS);
   assign wr_cnt0 = REG_WR & ((REG_ADDR == `OFS_LO0) | (REG_ADDR == `OFS_HI0));
   assign wr_cnt1 = REG_WR & ((REG_ADDR == `OFS_LO1) | (REG_ADDR == `OFS_HI1));
   assign ctl_base = wr_ctl ? REG_WDATA : q.ctl_flags;

   always_comb begin
      d = q;
      // pins pass two flops before use
      d.sync_a = {TIMER1_EVENT_PIN, TIMER0_EVENT_PIN, EXT_IRQ1_PIN, EXT_IRQ0_PIN};
      d.sync_b = q.sync_a;
      d.sync_prev = q.sync_b;

      d.pre0 = tick0 ? 4'h0 : q.pre0 + 4'h1;
      d.pre1 = tick1 ? 4'h0 : q.pre1 + 4'h1;

      // counting; a software write in the same cycle overrides it
      if (split0) begin
         if (inc0) begin
            d.lo0 = q.lo0 + 8'h01; // [RL11]
         end
         if (hi_inc) begin
            d.hi0 = q.hi0 + 8'h01; // [RL11]
         end
      end else if (inc0) begin
         {d.hi0, d.lo0} = step0[15:0];
      end
      if (inc1) begin
         {d.hi1, d.lo1} = step1[15:0];
      end

      // hardware set beats a vector clear or a software write of zero
      d.ctl_flags = ctl_base;
      d.ctl_flags[`CTL_OVF0] = (ctl_base[`CTL_OVF0] & ~VEC_TIMER0) | set_ovf0; // [RL1]
      d.ctl_flags[`CTL_OVF1] = (ctl_base[`CTL_OVF1] & ~VEC_TIMER1) | set_ovf1; // [RL1]
      if (q.ctl_flags[`CTL_EXT0_EDGE]) begin
         d.ctl_flags[`CTL_EXT0_FLAG] = (ctl_base[`CTL_EXT0_FLAG] & ~VEC_EXT0) | set_ext0; // [RL3]
      end else begin
         d.ctl_flags[`CTL_EXT0_FLAG] = set_ext0; // [RL3]
      end
      if (q.ctl_flags[`CTL_EXT1_EDGE]) begin
         d.ctl_flags[`CTL_EXT1_FLAG] = (ctl_base[`CTL_EXT1_FLAG] & ~VEC_EXT1) | set_ext1; // [RL3]
      end else begin
         d.ctl_flags[`CTL_EXT1_FLAG] = set_ext1; // [RL3]
      end

      d.sts = q.sts;
      if (REG_WR && (REG_ADDR == `OFS_INT_CLEAR)) begin
         d.sts = q.sts & ~REG_WDATA[3:0];
      end
      d.sts = d.sts | {set_ext1, set_ext0, set_ovf1, set_ovf0};

      if (REG_WR) begin
         unique case (REG_ADDR)
            `OFS_MODE_SEL:   d.mode_sel = REG_WDATA;
            `OFS_LO0:        d.lo0 = REG_WDATA; // [RL13]
            `OFS_HI0:        d.hi0 = REG_WDATA; // [RL13] [RL16]
            `OFS_LO1:        d.lo1 = REG_WDATA; // [RL13]
            `OFS_HI1:        d.hi1 = REG_WDATA; // [RL13] [RL16]
            `OFS_CLK_CFG:    d.clk_cfg = REG_WDATA[1:0];
            `OFS_INT_ENABLE: d.ien = REG_WDATA[3:0];
            default:         d.ien = q.ien;
         endcase
      end

      // read data stand for exactly the cycle after the strobe
      d.rdata = 8'h00;
      if (REG_RD) begin
         unique case (REG_ADDR)
            `OFS_CTL_FLAGS:  d.rdata = q.ctl_flags;
            `OFS_MODE_SEL:   d.rdata = q.mode_sel;
            `OFS_LO0:        d.rdata = q.lo0; // [RL13]
            `OFS_HI0:        d.rdata = q.hi0; // [RL13]
            `OFS_LO1:        d.rdata = q.lo1; // [RL13]
            `OFS_HI1:        d.rdata = q.hi1; // [RL13]
            `OFS_CLK_CFG:    d.rdata = {6'h00, q.clk_cfg};
            `OFS_INT_STATUS: d.rdata = {4'h0, q.sts};
            `OFS_INT_ENABLE: d.rdata = {4'h0, q.ien};
            default:         d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         q <= '0;
         // synchronisers start at the pins' pulled-up idle level, so a
         // level-mode flag or a false falling edge cannot follow reset [RL3]
         q.sync_a <= 4'hf;
         q.sync_b <= 4'hf;
         q.sync_prev <= 4'hf;
         q.ctl_flags <= `RST_CTL_FLAGS;
         q.mode_sel <= `RST_MODE_SEL; // [RL12]
         q.lo0 <= `RST_COUNT;
         q.hi0 <= `RST_COUNT;
         q.lo1 <= `RST_COUNT;
         q.hi1 <= `RST_COUNT;
      end else begin
         q <= d;
      end
   end

   assign REG_RDATA = q.rdata;
   assign IRQ = |(q.sts & q.ien);

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   chk_ovf0_sets_flag: assert property ( // [RL1] [RL14]
      ovf0 |=> q.ctl_flags[`CTL_OVF0])
      else $error("timer 0 overflow did not set its flag");

   chk_vector_clears_flag: assert property ( // [RL1]
      VEC_TIMER0 && !set_ovf0 && !wr_ctl |=> !q.ctl_flags[`CTL_OVF0])
      else $error("timer 0 flag not cleared on vectoring");

   chk_stopped_holds: assert property ( // [RL2]
      !q.ctl_flags[`CTL_RUN0] && !split0 && !wr_cnt0 |=> $stable(q.lo0) && $stable(q.hi0))
      else $error("stopped timer 0 changed its count");

   chk_level_follows: assert property ( // [RL3] [RL4]
      !q.ctl_flags[`CTL_EXT0_EDGE] && !wr_ctl
      |=> q.ctl_flags[`CTL_EXT0_FLAG] == !$past(q.sync_b[0]))
      else $error("level external flag does not follow the pin");

   chk_gate_blocks: assert property ( // [RL5]
      q.mode_sel[`MODE_TIMER0_PIN_GATING] && !q.sync_b[0] && !split0 && !wr_cnt0
      |=> $stable(q.lo0) && $stable(q.hi0))
      else $error("gated timer 0 counted with its pin low");

   chk_prescale_carry: assert property ( // [RL7] [RL15]
      inc0 && q.mode_sel[1:0] == 2'b00 && q.lo0[4:0] == 5'h1f && !wr_cnt0
      |=> q.lo0[4:0] == 5'h00 && q.lo0[7:5] == $past(q.lo0[7:5])
          && q.hi0 == $past(q.hi0) + 8'h01)
      else $error("prescaler carry into high byte wrong");

   chk_cascade_carry: assert property ( // [RL8]
      inc0 && q.mode_sel[1:0] == 2'b01 && q.lo0 == 8'hff && !wr_cnt0
      |=> q.lo0 == 8'h00 && q.hi0 == $past(q.hi0) + 8'h01)
      else $error("16-bit cascade carry wrong");

   chk_reload_value: assert property ( // [RL9] [RL16]
      inc0 && q.mode_sel[1:0] == 2'b10 && q.lo0 == 8'hff && !wr_cnt0
      |=> q.lo0 == $past(q.hi0) && $stable(q.hi0))
      else $error("auto-reload did not copy the high byte");

   chk_halt_holds: assert property ( // [RL10]
      q.mode_sel[5:4] == 2'b11 && !wr_cnt1 |=> $stable(q.lo1) && $stable(q.hi1))
      else $error("timer 1 in mode 3 changed its count");

   chk_split_flag: assert property ( // [RL11]
      split0 && q.ctl_flags[`CTL_RUN1] && tick0 && q.hi0 == 8'hff
      |=> q.ctl_flags[`CTL_OVF1])
      else $error("split high byte overflow did not set timer 1 flag");

   chk_reset_mode: assert property ( // [RL12]
      $past(SYS_RST) |-> q.mode_sel == 8'h00)
      else $error("mode register not zero after reset");

   chk_tick_spacing: assert property ( // [RL18]
      tick0 |=> !tick0 [*5])
      else $error("timer ticks closer than six periods");

endmodule

// ---- sim/pin_partner.sv ----
// far-side model of the interrupt and event pins
`timescale 1ns/1ps

module pin_partner (
   // clock
   input  wire logic clk,
   // pins, idle high as pulled-up lines
   output logic      ext_irq0_pin,
   output logic      ext_irq1_pin,
   output logic      timer0_event_pin,
   output logic      timer1_event_pin
);
   logic [1:0] ext_q = 2'b11;
   logic [1:0] ev_q  = 2'b11;

   assign {ext_irq1_pin, ext_irq0_pin}         = ext_q;
   assign {timer1_event_pin, timer0_event_pin} = ev_q;

   // six idle cycles cover the two sync flops plus edge detect
   task automatic set_ext(input int i, input logic v);
      @(posedge clk) ext_q[i] <= v;
      repeat (6) @(posedge clk);
   endtask

   // three cycles low and four high per fall, above the two-cycle minimum
   task automatic fall(input int i, input int n);
      repeat (n) begin
         @(posedge clk) ev_q[i] <= 1'b0;
         repeat (3) @(posedge clk);
         ev_q[i] <= 1'b1;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

// ---- sim/test_dual_timer_counter.sv ----
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`include "dual_timer_defines.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
   $display("wrong value at %0t: %h vs %h", $time, got, exp); end end

module test_dual_timer_counter;
   logic        ref_clk, sys_rst, reg_wr, reg_rd, x2_mode, irq;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, c, lo, hi, v;
   logic [3:0]  vec;
   logic [16:0] e;
   logic [31:0] seed = 32'h46f8;
   logic        ext0, ext1, ev0, ev1;
   logic [7:0]  adr [6] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h80};
   int          error_cnt = 0;
   int          checks_done = 0;
   int          t, m, k, i, ex;

   dual_timer_counter dual_timer_counter_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .EXT_IRQ0_PIN(ext0), .EXT_IRQ1_PIN(ext1),
      .TIMER0_EVENT_PIN(ev0), .TIMER1_EVENT_PIN(ev1), .X2_MODE(x2_mode),
      .VEC_TIMER0(vec[0]), .VEC_TIMER1(vec[1]), .VEC_EXT0(vec[2]), .VEC_EXT1(vec[3]),
      .IRQ(irq));

   pin_partner pin_partner_inst (.clk(ref_clk), .ext_irq0_pin(ext0), .ext_irq1_pin(ext1),
      .timer0_event_pin(ev0), .timer1_event_pin(ev1));

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // count model; mode 0 keeps the three upper prescaler bits as written
   function automatic logic [16:0] model(int md, int h, int l, int n);
      int ovf = 0;
      for (int j = 0; j < n; j++) begin
         if (md == 0) begin
            l = (l & 8'he0) | ((l + 1) & 8'h1f);
            if ((l & 31) == 0)
               h++;
         end else if (md == 1) begin
            l++;
            if (l == 256) begin
               l = 0;
               h++;
            end
         end else if (md == 2) begin
            l++;
            if (l == 256) begin
               l = h;
               ovf = 1;
            end
         end
         if (h == 256) begin
            h = 0;
            ovf = 1;
         end
      end
      return {ovf[0], h[7:0], l[7:0]};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] val);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= val;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] val);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 val = reg_rdata;
   endtask

   task automatic vec_pulse(input int n);
      @(posedge ref_clk) vec[n] <= 1'b1;
      @(posedge ref_clk) vec[n] <= 1'b0;
   endtask

   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (50000) @(posedge ref_clk);
      error_cnt++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      x2_mode = 1'b1;
      vec = 4'h0;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // whole map after reset, 0x8f being a hole
      for (k = 8'h88; k <= 8'h92; k++) begin
         rd(k[7:0], d);
         `CHK(d, 8'h00)
      end
      // count bytes take any value; status and holes ignore writes
      for (k = 0; k < 6; k++) begin
         v = rnd();
         wr(adr[k], v);
         rd(adr[k], d);
         `CHK(d, (k < 4) ? v : 8'h00)
      end
      // modes 0 to 2 on timer 0 and all four on timer 1, counted from event pins near rollover
      for (t = 0; t < 2; t++) begin
         for (m = 0; m < 3 + t; m++) begin
            lo = rnd() | 8'hfc;
            hi = (m == 2) ? rnd() : 8'hff;
            e = model(m, hi, lo, 4);
            wr(`OFS_MODE_SEL, 8'((m + 4) << (4 * t)));
            wr(8'(`OFS_LO0 + t), lo);
            wr(8'(`OFS_HI0 + t), hi);
            wr(`OFS_CTL_FLAGS, 8'h10 << (2 * t));
            pin_partner_inst.fall(t, 4);
            rd(`OFS_CTL_FLAGS, c);
            `CHK(c[5 + 2 * t], e[16])
            vec_pulse(t);
            rd(`OFS_CTL_FLAGS, c);
            `CHK(c[5 + 2 * t], 1'b0)
            wr(`OFS_CTL_FLAGS, 8'h00);
            pin_partner_inst.fall(t, 2);
            rd(8'(`OFS_LO0 + t), d);
            `CHK(d, e[7:0])
            rd(8'(`OFS_HI0 + t), d);
            `CHK(d, e[15:8])
         end
      end
      rd(`OFS_INT_STATUS, d);
      `CHK(d, 8'h03)
      wr(`OFS_INT_ENABLE, 8'h01);
      #1 `CHK(irq, 1'b1)
      wr(`OFS_INT_CLEAR, 8'h01);
      #1 `CHK(irq, 1'b0)
      // gated counter ignores falls while its pin is low
      wr(`OFS_MODE_SEL, 8'h0d);
      wr(`OFS_LO0, 8'h00);
      wr(`OFS_HI0, 8'h00);
      wr(`OFS_CTL_FLAGS, 8'h10);
      pin_partner_inst.set_ext(0, 1'b0);
      pin_partner_inst.fall(0, 2);
      pin_partner_inst.set_ext(0, 1'b1);
      pin_partner_inst.fall(0, 3);
      rd(`OFS_LO0, d);
      `CHK(d, 8'h03)
      // tick rate: x2, standard, halved, then split high byte on run1
      for (k = 0; k < 4; k++) begin
         x2_mode <= (k != 1);
         ex = (k == 1 || k == 2) ? 50 : 100;
         wr(`OFS_CLK_CFG, 8'(k == 2));
         wr(`OFS_MODE_SEL, (k == 3) ? 8'h03 : 8'h01);
         wr(`OFS_LO0, 8'h00);
         wr(`OFS_HI0, 8'h00);
         wr(`OFS_CTL_FLAGS, (k == 3) ? 8'h40 : 8'h10);
         repeat (600) @(posedge ref_clk);
         wr(`OFS_CTL_FLAGS, 8'h00);
         rd((k == 3) ? `OFS_HI0 : `OFS_LO0, d);
         `CHK(d >= ex - 2 && d <= ex + 2, 1'b1)
      end
      wr(`OFS_INT_CLEAR, 8'hff);
      wr(`OFS_INT_ENABLE, 8'h00);
      // edge flags clear on vectoring, level flags follow the pin
      for (i = 0; i < 2; i++) begin
         wr(`OFS_CTL_FLAGS, 8'h01 << (2 * i));
         pin_partner_inst.set_ext(i, 1'b0);
         rd(`OFS_CTL_FLAGS, c);
         `CHK(c, 8'h03 << (2 * i))
         vec_pulse(2 + i);
         rd(`OFS_CTL_FLAGS, c);
         `CHK(c, 8'h01 << (2 * i))
         wr(`OFS_CTL_FLAGS, 8'h00);
         vec_pulse(2 + i);
         rd(`OFS_CTL_FLAGS, c);
         `CHK(c, 8'h02 << (2 * i))
         pin_partner_inst.set_ext(i, 1'b1);
         rd(`OFS_CTL_FLAGS, c);
         `CHK(c, 8'h00)
      end
      rd(`OFS_INT_STATUS, d);
      `CHK(d, 8'h0c)
      `CHK(irq, 1'b0)
      wr(`OFS_INT_ENABLE, 8'h0c);
      #1 `CHK(irq, 1'b1)
      wr(`OFS_INT_CLEAR, 8'h0c);
      #1 `CHK(irq, 1'b0)
      final_report();
   end
endmodule
